// [src/host_message_interpreter.sv]
// Message parser, channel table, reply builder and low-power clock detection
module host_message_interpreter
(
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Received bytes from the serial layer (length, identifier, data)
	input  wire logic                       rx_valid_i,
	output logic                            rx_ready_o,
	input  wire logic [msg_pkg::BYTE_W-1:0] rx_data_i,
	// Channel events from the protocol engine
	input  wire logic                       ev_valid_i,
	output logic                            ev_ready_o,
	input  wire logic [msg_pkg::CH_W-1:0]   ev_chan_i,
	input  wire logic [msg_pkg::BYTE_W-1:0] ev_code_i,
	// Bytes to the serial layer
	output logic                            tx_valid_o,
	input  wire logic                       tx_ready_i,
	output logic [msg_pkg::BYTE_W-1:0]      tx_data_o,
	// Low-power clock pin and detection result
	input  wire logic                       low_power_clock_input_i,
	output logic                            use_ext_clock_o,
	output logic                            detect_done_o
);
	import msg_pkg::*;

	typedef enum logic [2:0]
	{
		RX_LEN  = 3'b000,
		RX_ID   = 3'b001,
		RX_DATA = 3'b011,
		EXEC    = 3'b010,
		SEND    = 3'b110
	} state_e;

	state_e           state;                 // Main sequencer
	byte_t            rx_len;                // Data length of incoming message
	byte_t            rx_id;                 // Identifier of incoming message
	byte_t            rx_buf [MAX_DATA];     // Incoming data bytes
	logic [IDX_W-1:0] rx_cnt;                // Data bytes taken so far
	byte_t            tx_len;                // Reply data length
	byte_t            tx_id;                 // Reply identifier
	byte_t            tx_buf [MAX_DATA];     // Reply data bytes
	byte_t            tx_idx;                // Reply byte being sent
	logic             ch_used [NUM_CH];      // Channel allocated
	byte_t            ch_type [NUM_CH];      // Channel type
	byte_t            ch_net  [NUM_CH];      // Network number
	logic [15:0]      ch_devnum [NUM_CH];    // Device number
	byte_t            ch_devtype [NUM_CH];   // Device type
	byte_t            ch_maker [NUM_CH];     // maker_identification_byte
	logic [15:0]      ch_period [NUM_CH];    // Message period
	byte_t            ch_tmo [NUM_CH];       // Search timeout
	byte_t            ch_freq [NUM_CH];      // Frequency index
	logic             lp_s1;                 // Synchroniser stages
	logic             lp_s2;
	logic             lp_prev;               // Edge detector history
	logic [DET_W-1:0] det_cnt;               // Detection window
	logic [1:0]       det_edges;             // Rising edges seen
	logic             det_busy;              // Window running

	// Channel number in range
	function automatic logic chan_ok(input byte_t c);
		chan_ok = (c < NUM_CH[BYTE_W-1:0]);
	endfunction

	// Expected data length of a configuration command, zero if not one
	function automatic byte_t cfg_len(input byte_t id);
		if (id == ID_RELEASE)       cfg_len = LEN_RELEASE;
		else if (id == ID_ALLOCATE) cfg_len = LEN_ALLOCATE;
		else if (id == ID_IDENTITY) cfg_len = LEN_IDENTITY;
		else if (id == ID_PERIOD)   cfg_len = LEN_PERIOD;
		else if (id == ID_TIMEOUT)  cfg_len = LEN_TIMEOUT;
		else if (id == ID_FREQ)     cfg_len = LEN_FREQ;
		else                        cfg_len = RST_BYTE;
	endfunction

	// Decode of the message just received
	wire [CH_W-1:0] ch       = rx_buf[0][CH_W-1:0];
	wire           is_cfg    = (cfg_len(rx_id) != RST_BYTE);
	wire           cfg_good  = (rx_len == cfg_len(rx_id)) && chan_ok(rx_buf[0]);
	wire           is_req    = (rx_id == ID_REQUEST) && (rx_len == LEN_REQUEST);
	wire           req_chan  = chan_ok(rx_buf[0]);
	wire [CH_W-1:0] req_ch   = rx_buf[0][CH_W-1:0];
	wire byte_t    req_id    = rx_buf[1];
	wire           last_data = (rx_cnt == rx_len[IDX_W-1:0] - 4'h1);

	// Handshakes; events wait while a host message is in flight
	assign rx_ready_o = (state == RX_LEN && !ev_valid_i) || state == RX_ID || state == RX_DATA;
	assign ev_ready_o = (state == RX_LEN);

	// Outgoing frame: length first, then identifier, then data
	byte_stream_if obuf ();
	assign obuf.valid = (state == SEND);
	assign obuf.data  = (tx_idx == RST_BYTE) ? tx_len :
	                    (tx_idx == 8'h01)    ? tx_id  : tx_buf[tx_idx[IDX_W-1:0] - 4'h2];
	wire   obuf_push  = obuf.valid && obuf.ready;
	wire   frame_end  = (tx_idx == tx_len + 8'h01);

	// Word-level framing is link neutral; UART or synchronous front end feeds it
	msg_byte_buffer u_buf
	(
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_s        (obuf),
		.out_valid_o (tx_valid_o),
		.out_ready_i (tx_ready_i),
		.out_data_o  (tx_data_o)
	);

	// Sequencer: parse, execute, reply
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state  <= RX_LEN;
			rx_len <= RST_BYTE;
			rx_id  <= RST_BYTE;
			rx_cnt <= '0;
			tx_len <= RST_BYTE;
			tx_id  <= RST_BYTE;
			tx_idx <= RST_BYTE;
			for (int i = 0; i < MAX_DATA; i++)
			begin
				rx_buf[i] <= RST_BYTE;
				tx_buf[i] <= RST_BYTE;
			end
		end
		else
		begin
			case (state)
				RX_LEN:
				begin
					rx_cnt <= '0;
					tx_idx <= RST_BYTE;
					if (ev_valid_i)
					begin
						// Channel event reported as a response message
						tx_len    <= LEN_RESPONSE;
						tx_id     <= ID_RESPONSE;
						tx_buf[0] <= {6'h00, ev_chan_i};
						tx_buf[1] <= ID_EVENT;
						tx_buf[2] <= ev_code_i;
						state     <= SEND;
					end
					else if (rx_valid_i)
					begin
						rx_len <= rx_data_i;
						state  <= RX_ID;
					end
				end
				RX_ID:
					if (rx_valid_i)
					begin
						rx_id <= rx_data_i;
						state <= (rx_len == RST_BYTE) ? EXEC : RX_DATA;
					end
				RX_DATA:
					if (rx_valid_i)
					begin
						// Overlong data is consumed but not stored, for lengths up to 16
						if (rx_cnt < MAX_DATA[IDX_W-1:0])
							rx_buf[rx_cnt] <= rx_data_i;
						rx_cnt <= rx_cnt + 4'h1;
						if (last_data)
							state <= EXEC;
					end
				EXEC:
				begin
					state <= SEND;
					if (is_cfg)
					begin
						// Every configuration command is answered
						tx_len    <= LEN_RESPONSE;
						tx_id     <= ID_RESPONSE;
						tx_buf[0] <= rx_buf[0];
						tx_buf[1] <= rx_id;
						tx_buf[2] <= cfg_good ? CODE_OK : CODE_INVALID;
					end
					else if (is_req && req_id == ID_STATUS && req_chan)
					begin
						tx_len    <= LEN_STATUS;
						tx_id     <= ID_STATUS;
						tx_buf[0] <= rx_buf[0];
						tx_buf[1] <= ch_used[req_ch] ? ST_ASSIGNED : ST_FREE;
					end
					else if (is_req && req_id == ID_IDENTITY && req_chan)
					begin
						tx_len    <= LEN_IDENTITY;
						tx_id     <= ID_IDENTITY;
						tx_buf[0] <= rx_buf[0];
						tx_buf[1] <= ch_devnum[req_ch][7:0];
						tx_buf[2] <= ch_devnum[req_ch][15:8];
						tx_buf[3] <= ch_devtype[req_ch];
						tx_buf[4] <= ch_maker[req_ch];
					end
					else if (is_req && req_id == ID_VERSION)
					begin
						// Channel byte of the request plays no part
						tx_len <= LEN_VERSION;
						tx_id  <= ID_VERSION;
						for (int i = 0; i < MAX_DATA; i++)
							tx_buf[i] <= VERSION_TEXT[(MAX_DATA-1-i)*BYTE_W +: BYTE_W];
					end
					else if (is_req && req_id == ID_CAPS)
					begin
						tx_len    <= LEN_CAPS;
						tx_id     <= ID_CAPS;
						tx_buf[0] <= NUM_CH[BYTE_W-1:0];
						tx_buf[1] <= CAP_NETWORKS;
						tx_buf[2] <= CAP_STD_OPT;
						tx_buf[3] <= CAP_ADV_OPT;
					end
					else if (rx_id == ID_REQUEST)
					begin
						// Unserviceable request gets a failure response
						tx_len    <= LEN_RESPONSE;
						tx_id     <= ID_RESPONSE;
						tx_buf[0] <= rx_buf[0];
						tx_buf[1] <= rx_id;
						tx_buf[2] <= CODE_INVALID;
					end
					else
						state <= RX_LEN; // Restart and unknown ids stay silent
				end
				SEND:
					if (obuf_push)
					begin
						tx_idx <= tx_idx + 8'h01;
						if (frame_end)
							state <= RX_LEN;
					end
				default:
					state <= RX_LEN;
			endcase
		end
	end

	// Soft restart frees every channel (ch_used only) and reruns clock detection
	wire restart = (state == EXEC) && (rx_id == ID_RESTART);
	wire cfg_wr  = (state == EXEC) && is_cfg && cfg_good;

	// Channel table; only accepted commands change it
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				ch_used[i]    <= 1'b0;
				ch_type[i]    <= RST_BYTE;
				ch_net[i]     <= RST_BYTE;
				ch_devnum[i]  <= '0;
				ch_devtype[i] <= RST_BYTE;
				ch_maker[i]   <= RST_BYTE;
				ch_period[i]  <= RST_PERIOD;
				ch_tmo[i]     <= RST_BYTE;
				ch_freq[i]    <= RST_BYTE;
			end
		end
		else if (restart)
		begin
			for (int i = 0; i < NUM_CH; i++)
				ch_used[i] <= 1'b0;
		end
		else if (cfg_wr)
		begin
			if (rx_id == ID_RELEASE)
				ch_used[ch] <= 1'b0;
			else if (rx_id == ID_ALLOCATE)
			begin
				ch_used[ch] <= 1'b1;
				ch_type[ch] <= rx_buf[1];
				ch_net[ch]  <= rx_buf[2];
			end
			else if (rx_id == ID_IDENTITY)
			begin
				ch_devnum[ch]  <= {rx_buf[2], rx_buf[1]};
				ch_devtype[ch] <= rx_buf[3];
				ch_maker[ch]   <= rx_buf[4];
			end
			else if (rx_id == ID_PERIOD)
				ch_period[ch] <= {rx_buf[2], rx_buf[1]};
			else if (rx_id == ID_TIMEOUT)
				ch_tmo[ch] <= rx_buf[1];
			else
				ch_freq[ch] <= rx_buf[1];
		end
	end

	// Pin synchroniser; a grounded pin reads as no clock
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lp_s1   <= 1'b0;
			lp_s2   <= 1'b0;
			lp_prev <= 1'b0;
		end
		else
		begin
			lp_s1   <= low_power_clock_input_i;
			lp_s2   <= lp_s1;
			lp_prev <= lp_s2;
		end
	end

	wire lp_rise = lp_s2 && !lp_prev;

	// Detection window after reset or soft restart; result held until next one
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			det_busy        <= 1'b1;
			det_cnt         <= '0;
			det_edges       <= 2'h0;
			use_ext_clock_o <= 1'b0;
		end
		else if (restart)
		begin
			det_busy  <= 1'b1;
			det_cnt   <= '0;
			det_edges <= 2'h0;
		end
		else if (det_busy)
		begin
			if (lp_rise && det_edges != 2'h3)
				det_edges <= det_edges + 2'h1;
			det_cnt <= det_cnt + 1'b1;
			if (det_cnt == DET_W'(DETECT_CYCLES - 1))
			begin
				det_busy        <= 1'b0;
				use_ext_clock_o <= (det_edges >= 2'(MIN_EDGES));
			end
		end
	end

	assign detect_done_o = !det_busy;

	// Checks
	property p_cfg_resp;
		@(posedge clk_i) disable iff (rst_i)
		(state == EXEC && is_cfg) |=> (tx_id == ID_RESPONSE && tx_len == LEN_RESPONSE
			&& tx_buf[1] == $past(rx_id) && state == SEND);
	endproperty
	a_cfg_resp: assert property (p_cfg_resp) else $error("config answer malformed");
	property p_status;
		@(posedge clk_i) disable iff (rst_i)
		(state == EXEC && is_req && req_id == ID_STATUS && req_chan)
			|=> (tx_id == ID_STATUS && tx_len == LEN_STATUS);
	endproperty
	a_status: assert property (p_status) else $error("status reply malformed");
	property p_ident;
		@(posedge clk_i) disable iff (rst_i)
		(state == EXEC && is_req && req_id == ID_IDENTITY && req_chan)
			|=> (tx_id == ID_IDENTITY && tx_len == LEN_IDENTITY);
	endproperty
	a_ident: assert property (p_ident) else $error("identity reply malformed");
	property p_version;
		@(posedge clk_i) disable iff (rst_i)
		(state == EXEC && is_req && req_id == ID_VERSION)
			|=> (tx_id == ID_VERSION && tx_len == LEN_VERSION);
	endproperty
	a_version: assert property (p_version) else $error("version reply malformed");
	property p_caps;
		@(posedge clk_i) disable iff (rst_i)
		(state == EXEC && is_req && req_id == ID_CAPS)
			|=> (tx_id == ID_CAPS && tx_len == LEN_CAPS && tx_buf[0] == 8'h04);
	endproperty
	a_caps: assert property (p_caps) else $error("capabilities reply malformed");
	property p_alloc;
		@(posedge clk_i) disable iff (rst_i)
		(cfg_wr && rx_id == ID_ALLOCATE) |=> ch_used[$past(ch)];
	endproperty
	a_alloc: assert property (p_alloc) else $error("allocation not stored");
	// Data bytes counted apart from the parser, so a wrong end of frame shows up
	byte_t n_data;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			n_data <= RST_BYTE;
		else if (state == RX_ID)
			n_data <= RST_BYTE; // Identifier stage opens a new count
		else if (state == RX_DATA && rx_valid_i)
			n_data <= n_data + 8'h01;
	end
	// Parser counter is four bits wide; longer frames are not held to this
	property p_frame_len;
		@(posedge clk_i) disable iff (rst_i)
		(state == EXEC && rx_len < 8'h10) |-> (n_data == rx_len);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame header wrong");
	property p_restart_det;
		@(posedge clk_i) disable iff (rst_i)
		restart |=> (det_busy && state == RX_LEN);
	endproperty
	a_restart_det: assert property (p_restart_det) else $error("restart missed");
	c_cfg:   cover property (@(posedge clk_i) disable iff (rst_i) cfg_wr);
	c_event: cover property (@(posedge clk_i) disable iff (rst_i) ev_valid_i && ev_ready_o);
	c_clock: cover property (@(posedge clk_i) disable iff (rst_i) $rose(use_ext_clock_o));
endmodule : host_message_interpreter

// [shared/msg_pkg.sv]
// Constants, message identifiers and timing for the host message interpreter
package msg_pkg;
	localparam int BYTE_W   = 8;             // Width of a link byte
	localparam int MAX_DATA = 9;             // Longest data field
	localparam int NUM_CH   = 4;             // Channels held in the table
	localparam int CH_W     = 2;             // Channel index width
	localparam int IDX_W    = 4;             // Byte counter width
	typedef logic [BYTE_W-1:0] byte_t;       // One link byte
	// Message identifiers
	localparam byte_t ID_RESPONSE = 8'h40;
	localparam byte_t ID_STATUS   = 8'h52;
	localparam byte_t ID_IDENTITY = 8'h51;
	localparam byte_t ID_VERSION  = 8'h3D;
	localparam byte_t ID_CAPS     = 8'h54;
	localparam byte_t ID_RELEASE  = 8'h41;
	localparam byte_t ID_ALLOCATE = 8'h42;
	localparam byte_t ID_PERIOD   = 8'h43;
	localparam byte_t ID_TIMEOUT  = 8'h44;
	localparam byte_t ID_FREQ     = 8'h45;
	localparam byte_t ID_RESTART  = 8'h4A;
	localparam byte_t ID_REQUEST  = 8'h4D;
	localparam byte_t ID_EVENT    = 8'h01;   // Message field of a channel event
	// Data lengths
	localparam byte_t LEN_RESPONSE = 8'h03;
	localparam byte_t LEN_STATUS   = 8'h02;
	localparam byte_t LEN_IDENTITY = 8'h05;
	localparam byte_t LEN_VERSION  = 8'h09;
	localparam byte_t LEN_CAPS     = 8'h04;
	localparam byte_t LEN_RELEASE  = 8'h01;
	localparam byte_t LEN_ALLOCATE = 8'h03;
	localparam byte_t LEN_PERIOD   = 8'h03;
	localparam byte_t LEN_TIMEOUT  = 8'h02;
	localparam byte_t LEN_FREQ     = 8'h02;
	localparam byte_t LEN_REQUEST  = 8'h02;
	// Result codes and status values
	localparam byte_t CODE_OK      = 8'h00;
	localparam byte_t CODE_INVALID = 8'h28;
	localparam byte_t ST_FREE      = 8'h00;
	localparam byte_t ST_ASSIGNED  = 8'h01;
	// Capabilities and version text; values are arbitrary
	localparam byte_t CAP_NETWORKS = 8'h03;
	localparam byte_t CAP_STD_OPT  = 8'h00;
	localparam byte_t CAP_ADV_OPT  = 8'h00;
	localparam logic [MAX_DATA*BYTE_W-1:0] VERSION_TEXT = 72'h41_42_43_2D_31_2E_30_30_00;
	// Reset values of channel fields
	localparam byte_t      RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_PERIOD = 16'h2000;
	// Low-power clock detection window
	localparam int CLK_MHZ        = 40;
	localparam int DETECT_TIME_US = 100;     // About three periods at 32.768 kHz
	localparam int DETECT_CYCLES  = DETECT_TIME_US * CLK_MHZ;
	localparam int DET_W          = 12;
	localparam int MIN_EDGES      = 2;       // Rising edges that prove a clock
endpackage : msg_pkg

// [shared/byte_stream_if.sv]
// Valid/ready byte stream between the interpreter and its output buffer
interface byte_stream_if;
	logic                    valid; // Byte offered
	logic                    ready; // Byte accepted
	logic [msg_pkg::BYTE_W-1:0] data;  // Byte value
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// [src/msg_byte_buffer.sv]
// Two-entry output buffer; read data come straight from a register
module msg_byte_buffer
(
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Filling side
	byte_stream_if.snk                      in_s,
	// Draining side
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [msg_pkg::BYTE_W-1:0]      out_data_o
);
	import msg_pkg::*;

	byte_t      slot0;  // Head word, drives the output
	byte_t      slot1;  // Second word
	logic [1:0] count;  // Words held

	wire push = in_s.valid && in_s.ready;
	wire pop  = out_valid_o && out_ready_i;

	// Full only at two words, so a stalled receiver holds back the source
	assign in_s.ready  = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign out_data_o  = slot0;

	// Shift-style storage keeps the head in one fixed register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			slot0 <= RST_BYTE;
			slot1 <= RST_BYTE;
			count <= 2'h0;
		end
		else
		begin
			if (pop)
				slot0 <= (count == 2'h2) ? slot1 : in_s.data;
			else if (push && count == 2'h0)
				slot0 <= in_s.data;
			if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop)))
				slot1 <= in_s.data;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : msg_byte_buffer

// [testbench/host_model.sv]
// Host side model: drains reply bytes, promptly or with random stalls
module host_model
(
	// Clock
	input  wire logic clk_i,
	// Reply stream from the device
	input  wire logic tx_valid_i,
	output logic      tx_ready_o,
	// Stall mode and take strobe
	input  wire logic stall_en_i,
	output logic      take_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Ready moves at the falling edge, away from sampling; byte link of either kind
	initial tx_ready_o = 1'b1;
	always @(negedge clk_i)
	begin
		tx_ready_o <= stall_en_i ? ($urandom_range(3) != 0) : 1'b1;
	end
	// A byte moves on each rising edge where both are high
	assign take_o = tx_valid_i & tx_ready_o;
endmodule // host_model

// [testbench/host_message_interpreter_tb.sv]
// Self-checking bench for the host message interpreter
module host_message_interpreter_tb;
	import msg_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic            clk_i, rst_i, rx_valid, rx_ready, ev_valid, ev_ready;
	logic            tx_valid, tx_ready, lp, lp_en, use_ext, det_done, stall_en, take;
	logic [CH_W-1:0] ev_chan;
	byte_t           rx_data, ev_code, tx_data;
	byte_t           got_q[$], exp_q[$], fr[$];  // Output seen, output due, frame data
	logic            asg [NUM_CH];               // Channel allocated
	byte_t           idn [NUM_CH][4];            // Identity bytes per channel
	int              bad_count, n_compared;

	host_message_interpreter DUT (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid),
		.rx_ready_o(rx_ready), .rx_data_i(rx_data), .ev_valid_i(ev_valid),
		.ev_ready_o(ev_ready), .ev_chan_i(ev_chan), .ev_code_i(ev_code),
		.tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
		.low_power_clock_input_i(lp), .use_ext_clock_o(use_ext), .detect_done_o(det_done));
	host_model host (.clk_i(clk_i), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.stall_en_i(stall_en), .take_o(take));

	// 40 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Low-power clock, held at ground until supplied, then left running
	initial
	begin
		lp = 1'b0;
		forever #15259 lp = lp_en ? ~lp : 1'b0;
	end
	// Collect every byte the host takes
	always @(posedge clk_i)
		if (take === 1'b1)
			got_q.push_back(tx_data);

	task report_and_stop;
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input byte_t e, input byte_t a);
		n_compared++;
		if (a !== e)
		begin
			bad_count++;
			$display("ERROR %0t exp %h got %h", $time, e, a);
		end
	endtask
	// Bounded wait ran out
	task give_up;
		check(8'h01, 8'h00);
		report_and_stop;
	endtask
	// Expected data length of a command
	function automatic byte_t exp_len(byte_t id);
		case (id)
			ID_RELEASE:            return LEN_RELEASE;
			ID_ALLOCATE, ID_PERIOD: return LEN_ALLOCATE;
			ID_IDENTITY:           return LEN_IDENTITY;
			default:               return LEN_TIMEOUT;
		endcase
	endfunction
	// Result code of a command
	function automatic byte_t exp_code(byte_t id, int n, byte_t ch);
		return (n == exp_len(id) && ch < NUM_CH) ? CODE_OK : CODE_INVALID;
	endfunction
	// Send length, id and data; length counts data only
	task send_frame(input byte_t id);
		byte_t all[$];
		int t;
		all = fr;
		all.push_front(id);
		all.push_front(byte_t'(fr.size()));
		foreach (all[i])
		begin
			@(negedge clk_i);
			rx_valid = 1'b1;
			rx_data = all[i];
			t = 0;
			while (rx_ready !== 1'b1)
			begin
				@(negedge clk_i);
				t++;
				if (t > 300)
					give_up;
			end
			@(posedge clk_i);
		end
		@(negedge clk_i);
		rx_valid = 1'b0;
	endtask
	// Wait for the due bytes, then compare in order
	task expect_out;
		int t;
		t = 0;
		while (got_q.size() < exp_q.size())
		begin
			@(negedge clk_i);
			t++;
			if (t > 600)
				give_up;
		end
		foreach (exp_q[i])
			check(exp_q[i], got_q.pop_front());
		exp_q = {};
	endtask
	// Configuration command with n data bytes on channel ch
	task cmd(input byte_t id, input int n, input byte_t ch);
		byte_t c;
		fr = {ch};
		repeat (n - 1) fr.push_back(byte_t'($urandom()));
		c = exp_code(id, n, ch);
		if (c == CODE_OK && id == ID_ALLOCATE)
			asg[ch] = 1'b1;
		if (c == CODE_OK && id == ID_RELEASE)
			asg[ch] = 1'b0;
		if (c == CODE_OK && id == ID_IDENTITY)
			idn[ch] = '{fr[1], fr[2], fr[3], fr[4]};
		exp_q = {LEN_RESPONSE, ID_RESPONSE, ch, id, c};
		send_frame(id);
		expect_out;
	endtask
	// Request a reply message
	task req(input byte_t ch, input byte_t m);
		fr = {ch, m};
		if (m == ID_STATUS && ch < NUM_CH)
			exp_q = {LEN_STATUS, ID_STATUS, ch, asg[ch] ? ST_ASSIGNED : ST_FREE};
		else if (m == ID_IDENTITY && ch < NUM_CH)
			exp_q = {LEN_IDENTITY, ID_IDENTITY, ch, idn[ch][0], idn[ch][1], idn[ch][2],
				idn[ch][3]};
		else if (m == ID_VERSION)
		begin
			exp_q = {LEN_VERSION, ID_VERSION};
			for (int i = 0; i < MAX_DATA; i++)
				exp_q.push_back(VERSION_TEXT[(MAX_DATA-i)*BYTE_W-1 -: BYTE_W]);
		end
		else if (m == ID_CAPS)
			exp_q = {LEN_CAPS, ID_CAPS, byte_t'(NUM_CH), CAP_NETWORKS, CAP_STD_OPT, CAP_ADV_OPT};
		else
			exp_q = {LEN_RESPONSE, ID_RESPONSE, ch, ID_REQUEST, CODE_INVALID};
		send_frame(ID_REQUEST);
		expect_out;
	endtask
	// Channel event from the protocol engine
	task event_in(input int c, input byte_t code);
		int t;
		@(negedge clk_i);
		ev_valid = 1'b1;
		ev_chan = c[CH_W-1:0];
		ev_code = code;
		t = 0;
		while (ev_ready !== 1'b1)
		begin
			@(negedge clk_i);
			t++;
			if (t > 300)
				give_up;
		end
		@(posedge clk_i);
		@(negedge clk_i);
		ev_valid = 1'b0;
		exp_q = {LEN_RESPONSE, ID_RESPONSE, byte_t'(c), ID_EVENT, code};
		expect_out;
	endtask
	// Wait for the end of a detection window
	task wait_detect;
		int t;
		t = 0;
		while (det_done !== 1'b1)
		begin
			@(negedge clk_i);
			t++;
			if (t > 6000)
				give_up;
		end
	endtask

	// Main sequence
	initial
	begin
		byte_t ids[6];
		byte_t id;
		int n;
		ids = '{ID_RELEASE, ID_ALLOCATE, ID_IDENTITY, ID_PERIOD, ID_TIMEOUT, ID_FREQ};
		{rx_valid, ev_valid, ev_chan, rx_data, ev_code, lp_en, stall_en} = '0;
		bad_count = 0;
		n_compared = 0;
		foreach (asg[i])
			asg[i] = 1'b0;
		foreach (idn[i, j])
			idn[i][j] = RST_BYTE;
		void'($urandom(54));
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		wait_detect;
		check(8'h00, byte_t'(use_ext));
		for (int c = 0; c < NUM_CH; c++)
			cmd(ID_ALLOCATE, 3, byte_t'(c));
		stall_en = 1'b1;
		cmd(ID_ALLOCATE, 3, 8'h04);
		// Random commands, some with a wrong length or channel
		repeat (40)
		begin
			id = ids[$urandom_range(5)];
			n = exp_len(id);
			if ($urandom_range(3) == 0)
				n = (n > 1 && $urandom_range(1)) ? n - 1 : n + 1;
			cmd(id, n, byte_t'($urandom_range(5)));
		end
		cmd(ID_IDENTITY, 5, 8'h02);
		// Overlong frame: extra data consumed, length refused
		cmd(ID_PERIOD, 11, 8'h01);
		req(8'h02, ID_IDENTITY);
		for (int c = 0; c <= NUM_CH; c++)
			req(byte_t'(c), ID_STATUS);
		req(8'h00, ID_VERSION);
		req(8'h01, ID_CAPS);
		req(8'h00, 8'h77);
		for (int c = 0; c < NUM_CH; c++)
			event_in(c, byte_t'($urandom()));
		// Soft restart with the low-power clock now supplied: silent, frees channels
		lp_en = 1'b1;
		fr = {8'h00};
		send_frame(ID_RESTART);
		repeat (40) @(negedge clk_i);
		check(8'h00, byte_t'(got_q.size()));
		wait_detect;
		check(8'h01, byte_t'(use_ext));
		foreach (asg[i])
			asg[i] = 1'b0;
		for (int c = 0; c < NUM_CH; c++)
			req(byte_t'(c), ID_STATUS);
		report_and_stop;
	end
endmodule // host_message_interpreter_tb
